// ===== verilog/antenna_pkg.sv
// Shared constants for the antenna driver control block
package antenna_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] CONTROL_INDEX = 16'h6304;
   localparam logic [15:0] AUTO_INDEX = 16'h6305;
   localparam logic [31:0] CONTROL_ADDR = {14'h0000, CONTROL_INDEX, 2'b00};
   localparam logic [31:0] AUTO_ADDR = {14'h0000, AUTO_INDEX, 2'b00};
   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h80;
   localparam logic [7:0] AUTO_RESET = 8'h00;
   // Driver control register fields
   localparam int INV_B_ON_BIT = 7;
   localparam int INV_A_ON_BIT = 6;
   localparam int INV_B_OFF_BIT = 5;
   localparam int INV_A_OFF_BIT = 4;
   localparam int CONT_CARRIER_BIT = 3;
   localparam int FIELD_CHECK_BIT = 2;
   localparam int EN_B_BIT = 1;
   localparam int EN_A_BIT = 0;
   // Automatic control register fields
   localparam int AUTO_OFF_BIT = 7;
   localparam int FULL_ASK_BIT = 6;
   localparam int WAKE_BIT = 5;
   localparam int CA_BIT = 3;
   localparam int INITIAL_BIT = 2;
   localparam int AUTO_B_BIT = 1;
   localparam int AUTO_A_BIT = 0;
   // Timing
   localparam int CLOCK_MHZ = 10;
   localparam int ACTIVATION_DELAY_US = 100;
   localparam int INITIAL_DELAY_US = 400;
   localparam int RF_WAIT_US = 20;
   localparam int ACTIVATION_DELAY_CYCLES = ACTIVATION_DELAY_US * CLOCK_MHZ;
   localparam int INITIAL_DELAY_CYCLES = INITIAL_DELAY_US * CLOCK_MHZ;
   localparam int RF_WAIT_CYCLES = RF_WAIT_US * CLOCK_MHZ;
   localparam int TIMER_WIDTH = 16;
   localparam int SLOT_WIDTH = 2;
   // Slot generator seed and taps
   localparam logic [7:0] LFSR_SEED = 8'h5a;
   localparam logic [7:0] LFSR_TAPS = 8'hb8;
   // Sequencer states
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ACT_WAIT, SEQ_INIT_WAIT} seq_state_type;
endpackage

// ===== verilog/auto_seq_if.sv
// Signals between the register bank and the field sequencer
`timescale 1ns/1ps
interface auto_seq_if;
   logic field_present; // Synchronised external field
   logic auto_a; // Driver A auto enable
   logic auto_b; // Driver B auto enable
   logic initial_req; // Initial collision avoidance pending
   logic check_rf; // Refuse set while field seen
   logic own_field_on; // Any driver carrier enabled
   logic ca_on; // Collision avoidance enabled
   logic [1:0] slot_n; // Chosen slot count
   logic set_a; // Pulse: set driver A enable
   logic set_b; // Pulse: set driver B enable
   logic initial_done; // Pulse: clear initial request
   logic timer_start; // Pulse: new delay started
   modport ctrl (output auto_a, auto_b, initial_req, check_rf, own_field_on, ca_on, slot_n,
      field_present, input set_a, set_b, initial_done, timer_start);
   modport seq (input auto_a, auto_b, initial_req, check_rf, own_field_on, ca_on, slot_n,
      field_present, output set_a, set_b, initial_done, timer_start);
endinterface

// ===== verilog/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_q; // First stage, read only by second
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] level_q;
   logic [W-1:0] level_d;

   // Accept a change once two late stages agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
      end
   end

   // Stage registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         level_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_q <= level_d;
      end
   end

   assign level = level_q;
endmodule

// ===== verilog/field_sequencer.sv
// Automatic field switch-on and initial collision avoidance timer
`timescale 1ns/1ps
module field_sequencer
   import antenna_pkg::*;
#(
   parameter int ACT_CYCLES = ACTIVATION_DELAY_CYCLES,
   parameter int INIT_CYCLES = INITIAL_DELAY_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   auto_seq_if.seq bus
);
   seq_state_type state_q, state_d;
   logic [TIMER_WIDTH-1:0] cnt_q, cnt_d; // Quiet-time counter
   logic seen_q, seen_d; // External field was seen
   logic [TIMER_WIDTH-1:0] act_target; // Activation wait plus slots
   logic fire;
   logic any_auto;

   // Collision avoidance stretches the wait by n slot times
   assign act_target = TIMER_WIDTH'(ACT_CYCLES)
      + (bus.ca_on ? TIMER_WIDTH'(bus.slot_n) * TIMER_WIDTH'(RF_WAIT_CYCLES) : '0);
   assign any_auto = bus.auto_a | bus.auto_b;

   // Next state and counter
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      seen_d = seen_q;
      fire = 1'b0;
      bus.timer_start = 1'b0;
      unique case (state_q)
         SEQ_IDLE: begin
            if (bus.field_present) begin
               seen_d = 1'b1;
            end else if (bus.initial_req && any_auto && !bus.own_field_on) begin
               state_d = SEQ_INIT_WAIT;
               cnt_d = '0;
               seen_d = 1'b0;
               bus.timer_start = 1'b1;
            end else if (seen_q && any_auto && !bus.own_field_on) begin
               state_d = SEQ_ACT_WAIT;
               cnt_d = '0;
               seen_d = 1'b0;
               bus.timer_start = 1'b1;
            end
         end
         SEQ_ACT_WAIT, SEQ_INIT_WAIT: begin
            if (bus.field_present) begin
               // Field returned: no switch-on, wait for it to go again
               state_d = SEQ_IDLE;
               seen_d = 1'b1;
            end else if (bus.own_field_on || !any_auto) begin
               state_d = SEQ_IDLE;
            end else if (cnt_q == ((state_q == SEQ_ACT_WAIT) ? act_target - 1'b1
                  : TIMER_WIDTH'(INIT_CYCLES - 1))) begin
               fire = 1'b1;
               state_d = SEQ_IDLE;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
      endcase
   end

   // Switch-on pulses, refused while a field is sensed under check
   always_comb begin
      bus.set_a = fire && bus.auto_a && !(bus.check_rf && bus.field_present);
      bus.set_b = fire && bus.auto_b && !(bus.check_rf && bus.field_present);
      bus.initial_done = fire && (state_q == SEQ_INIT_WAIT);
   end

   // State registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SEQ_IDLE;
         cnt_q <= '0;
         seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         seen_q <= seen_d;
      end
   end
endmodule

// ===== verilog/antenna_driver_control.sv
// Antenna driver control register bank with Wishbone slave
//
// Summary of operation
// - Invert driver B by on/off state bits
// - Invert driver A by on/off state bits
// - Continuous carrier bit stops driver B modulation
// - Field check refuses automatic enables under field
// - Driver B enable gives modulated carrier
// - Driver A enable gives modulated carrier
// - Auto field off after last transmitted bit
// - Force full ASK overriding depth setting
// - RF detector wakes from power-down when enabled
// - Collision avoidance enable chooses slot count
// - Initial avoidance bit self-clears on switch-on
// - Bit stays set if field already on
// - Driver B auto enable after activation delay
// - Initial avoidance needs quiet initial delay
// - Driver A auto enable, same timing as B
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module antenna_driver_control
   import antenna_pkg::*;
#(
   parameter int ACT_CYCLES = ACTIVATION_DELAY_CYCLES,
   parameter int INIT_CYCLES = INITIAL_DELAY_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_field_in,
   input wire logic rf_level_in,
   input wire logic tx_envelope,
   input wire logic tx_last_bit,
   input wire logic power_down,
   output logic driver_a_pin,
   output logic driver_b_pin,
   output logic force_full_ask,
   output logic collision_avoid_enable,
   output logic [1:0] collision_slot,
   output logic wake_request
);
   auto_seq_if seq_bus (); // Link to the sequencer

   // Synchronised pin levels
   logic [1:0] pin_level;
   logic field_present; // External field sensed
   logic rf_level; // RF level detector

   // Bus handshake
   logic ack_q; // Answer pulse
   logic ack_d;
   logic [31:0] dat_q;
   logic [31:0] dat_d;
   logic req; // Fresh request this cycle
   logic wr_ctrl; // Write lands on driver control
   logic wr_auto; // Write lands on automatic control

   // Driver control register state
   logic [7:0] ctrl_q; // Bit 2 is never stored here
   logic [7:0] ctrl_d;
   logic check_q; // Write-only field check
   logic check_d;

   // Automatic control register state
   logic [7:0] auto_q; // Bits 4 and 2 kept zero here
   logic [7:0] auto_d;
   logic initial_q; // Write-only initial request
   logic initial_d;

   // Output state
   logic pin_a_q;
   logic pin_a_d;
   logic pin_b_q;
   logic pin_b_d;
   logic wake_q;
   logic wake_d;
   logic [7:0] lfsr_q; // Free running slot source
   logic [7:0] lfsr_d;
   logic [1:0] slot_q;
   logic [1:0] slot_d;

   // Working terms
   logic en_a;
   logic en_b;
   logic inv_a;
   logic inv_b;
   logic carrier_a;
   logic carrier_b;

   // Pin synchroniser for both detector inputs
   // Both pins async
   pin_sync #(
      .W(2)
   ) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin({rf_level_in, ext_field_in}),
      .level(pin_level)
   );
   // Split levels
   assign field_present = pin_level[0];
   assign rf_level = pin_level[1];

   // Delay sequencer
   // Same delays
   field_sequencer #(
      .ACT_CYCLES(ACT_CYCLES),
      .INIT_CYCLES(INIT_CYCLES)
   ) u_seq (
      .mclk(mclk),
      .rst_n(rst_n),
      .bus(seq_bus.seq)
   );

   // Settings handed to the sequencer
   assign seq_bus.field_present = field_present;
   assign seq_bus.auto_a = auto_q[AUTO_A_BIT];
   assign seq_bus.auto_b = auto_q[AUTO_B_BIT];
   assign seq_bus.initial_req = initial_q;
   assign seq_bus.check_rf = check_q;
   // Either carrier on
   assign seq_bus.own_field_on = ctrl_q[EN_A_BIT] | ctrl_q[EN_B_BIT];
   // Stretches the wait
   assign seq_bus.ca_on = auto_q[CA_BIT];
   assign seq_bus.slot_n = slot_q;

   // Request decode; write takes effect on the acknowledged edge
   always_comb begin
      req = wb_cyc_i && wb_stb_i && !ack_q;
      // Byte lane 0 only
      wr_ctrl = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]
         && (wb_adr_i == CONTROL_ADDR);
      wr_auto = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]
         && (wb_adr_i == AUTO_ADDR);
   end

   // Bus answer: one cycle after request, any address acked
   always_comb begin
      // One wait state
      ack_d = req;
      // Hold read data
      dat_d = dat_q;
      if (req) begin
         // Unmapped reads return zero
         dat_d = 32'h0000_0000;
         if (wb_adr_i == CONTROL_ADDR) begin
            // Field check reads as zero
            dat_d[7:0] = {ctrl_q[7:3], 1'b0, ctrl_q[1:0]};
         end else if (wb_adr_i == AUTO_ADDR) begin
            // Initial bit and reserved bit read as zero
            dat_d[7:0] = {auto_q[7:5], 1'b0, auto_q[3], 1'b0, auto_q[1:0]};
         end
      end
   end

   // Driver control next value
   always_comb begin
      // Keep unless written
      ctrl_d = ctrl_q;
      check_d = check_q;

      // Software write
      if (wr_ctrl) begin
         ctrl_d = {wb_dat_i[7:3], 1'b0, wb_dat_i[1:0]};
         check_d = wb_dat_i[FIELD_CHECK_BIT];
      end

      // Own field switched off once the last bit has gone out
      if (tx_last_bit && auto_q[AUTO_OFF_BIT]) begin
         ctrl_d[EN_A_BIT] = 1'b0;
         ctrl_d[EN_B_BIT] = 1'b0;
      end

      // Hardware set wins over any clear in the same cycle
      if (seq_bus.set_a) begin
         ctrl_d[EN_A_BIT] = 1'b1;
      end
      if (seq_bus.set_b) begin
         ctrl_d[EN_B_BIT] = 1'b1;
      end
   end

   // Automatic control next value
   always_comb begin
      // Keep unless written
      auto_d = auto_q;
      initial_d = initial_q;

      // Hardware clears it only on a real switch-on, so it stays if field was on
      if (seq_bus.initial_done) begin
         initial_d = 1'b0;
      end

      // Software write
      if (wr_auto) begin
         auto_d = {wb_dat_i[7:5], 1'b0, wb_dat_i[3], 1'b0, wb_dat_i[1:0]};
         // A fresh start request beats a same-cycle clear
         initial_d = wb_dat_i[INITIAL_BIT];
      end
   end

   // Driver pin levels
   always_comb begin
      // Register enables
      en_a = ctrl_q[EN_A_BIT];
      en_b = ctrl_q[EN_B_BIT];
      // Carrier present unless the envelope pauses it
      carrier_a = en_a && !tx_envelope;
      // Continuous mode ignores the envelope on driver B
      carrier_b = en_b && (ctrl_q[CONT_CARRIER_BIT] || !tx_envelope);
      // Invert by state
      inv_a = en_a ? ctrl_q[INV_A_ON_BIT] : ctrl_q[INV_A_OFF_BIT];
      inv_b = en_b ? ctrl_q[INV_B_ON_BIT] : ctrl_q[INV_B_OFF_BIT];
      // Registered, no glitch
      pin_a_d = carrier_a ^ inv_a;
      pin_b_d = carrier_b ^ inv_b;
   end

   // Wake and slot choice
   always_comb begin
      // Level held while detector sees RF during power-down
      wake_d = auto_q[WAKE_BIT] && power_down && rf_level;
      // Steps every cycle
      lfsr_d = {lfsr_q[6:0], ^(lfsr_q & LFSR_TAPS)};
      // Held between delays
      slot_d = slot_q;
      // New slot count for each delay when avoidance is on
      if (seq_bus.timer_start && auto_q[CA_BIT]) begin
         slot_d = lfsr_q[SLOT_WIDTH-1:0];
      end
   end

   // Bus registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // Idle bus
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         // Next values
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // Register bank
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // Carriers off
         ctrl_q <= CONTROL_RESET;
         check_q <= 1'b0;
         auto_q <= AUTO_RESET;
         initial_q <= 1'b0;
      end else begin
         // Next values
         ctrl_q <= ctrl_d;
         check_q <= check_d;
         auto_q <= auto_d;
         initial_q <= initial_d;
      end
   end

   // Output registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // Pins idle low
         pin_a_q <= 1'b0;
         pin_b_q <= 1'b0;
         wake_q <= 1'b0;
         // Non-zero seed or it sticks
         lfsr_q <= LFSR_SEED;
         slot_q <= 2'h0;
      end else begin
         // Next values
         pin_a_q <= pin_a_d;
         pin_b_q <= pin_b_d;
         wake_q <= wake_d;
         lfsr_q <= lfsr_d;
         slot_q <= slot_d;
      end
   end

   // Port drives
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Driver gates
   assign driver_a_pin = pin_a_q;
   assign driver_b_pin = pin_b_q;
   // Depth setting downstream is overridden while this is high
   assign force_full_ask = auto_q[FULL_ASK_BIT];
   assign collision_avoid_enable = auto_q[CA_BIT];

   // Slot and wake
   assign collision_slot = slot_q;
   assign wake_request = wake_q;
endmodule

// ===== verif/field_partner.sv
// Far side: external reader field source and antenna coil
`timescale 1ns/1ps
module field_partner #(
   parameter int LAG = 2
) (
   input wire logic mclk,
   input wire logic field_cmd,
   input wire logic driver_a_pin,
   input wire logic driver_b_pin,
   output logic ext_field_in,
   output logic rf_level_in,
   output logic coil_on
);
   logic [LAG-1:0] dly_q = '0; // Distant reader: field arrives late
   // Field reaches the detector some cycles after the command
   always @(posedge mclk) begin
      dly_q <= {dly_q[LAG-2:0], field_cmd};
   end
   assign ext_field_in = dly_q[LAG-1];
   assign rf_level_in = dly_q[LAG-1];
   // Coil is energised while either driver gate is active
   assign coil_on = driver_a_pin | driver_b_pin;
endmodule

// ===== verif/antenna_chk.sv
// Port-level assertions for the antenna driver control block
`timescale 1ns/1ps
module antenna_chk
   import antenna_pkg::*;
#(
   parameter int ACT_CYCLES = ACTIVATION_DELAY_CYCLES,
   parameter int INIT_CYCLES = INITIAL_DELAY_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic tx_envelope,
   input wire logic power_down,
   input wire logic driver_a_pin,
   input wire logic driver_b_pin,
   input wire logic force_full_ask,
   input wire logic collision_avoid_enable,
   input wire logic wake_request
);
   logic wr_any; // Accepted low-byte write
   logic wr_ctl; // Write to control register
   logic wr_aut; // Write to automatic register
   logic [7:0] ctl_q; // Software view of control
   logic [7:0] ctl_d;
   logic wake_q; // Software view of wake enable
   logic wake_d;
   logic autos_q; // Any automatic enable or auto-off armed
   logic autos_d;
   logic ok_q; // Shadow exact: nothing automatic moves enables
   logic ok_d;
   assign wr_any = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wr_ctl = wr_any & (wb_adr_i == CONTROL_ADDR);
   assign wr_aut = wr_any & (wb_adr_i == AUTO_ADDR);
   function automatic logic pin_f(logic en, logic ion, logic ioff, logic env, logic cw);
      return (en & (cw | ~env)) ^ (en ? ion : ioff);
   endfunction
   // Shadow next state; trust regained only by a control write
   always_comb begin
      ctl_d = wr_ctl ? wb_dat_i[7:0] : ctl_q;
      wake_d = wr_aut ? wb_dat_i[WAKE_BIT] : wake_q;
      autos_d = wr_aut ? (|{wb_dat_i[AUTO_OFF_BIT], wb_dat_i[1:0]}) : autos_q;
      ok_d = wr_aut ? (ok_q & ~autos_d) : (wr_ctl ? ~autos_q : ok_q);
   end
   // Shadow registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= CONTROL_RESET;
         wake_q <= 1'b0;
         autos_q <= 1'b0;
         ok_q <= 1'b1;
      end else begin
         ctl_q <= ctl_d;
         wake_q <= wake_d;
         autos_q <= autos_d;
         ok_q <= ok_d;
      end
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o ##1 1'b1 |-> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_dat_hold;
      !wb_ack_o |-> $stable(wb_dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
   property p_aut_write;
      wr_aut |=> force_full_ask == $past(wb_dat_i[FULL_ASK_BIT])
         && collision_avoid_enable == $past(wb_dat_i[CA_BIT]);
   endproperty
   a_aut_write: assert property (p_aut_write) else $error("ask or ca wrong");
   property p_aut_hold;
      !wr_aut |=> $stable({force_full_ask, collision_avoid_enable});
   endproperty
   a_aut_hold: assert property (p_aut_hold) else $error("ask or ca moved");
   property p_wake;
      wake_request |-> $past(power_down) && $past(wake_q);
   endproperty
   a_wake: assert property (p_wake) else $error("wake unexpected");
   property p_pin_a;
      ok_q && $past(ok_q) |-> driver_a_pin == pin_f($past(ctl_q[EN_A_BIT]),
         $past(ctl_q[INV_A_ON_BIT]), $past(ctl_q[INV_A_OFF_BIT]), $past(tx_envelope), 1'b0);
   endproperty
   a_pin_a: assert property (p_pin_a) else $error("pin a wrong");
   property p_pin_b;
      ok_q && $past(ok_q) |-> driver_b_pin == pin_f($past(ctl_q[EN_B_BIT]),
         $past(ctl_q[INV_B_ON_BIT]), $past(ctl_q[INV_B_OFF_BIT]), $past(tx_envelope),
         $past(ctl_q[CONT_CARRIER_BIT]));
   endproperty
   a_pin_b: assert property (p_pin_b) else $error("pin b wrong");
   c_ask: cover property (wr_aut ##1 force_full_ask);
   c_wake: cover property (wake_request);
   c_pin_b: cover property (ok_q && driver_b_pin);
endmodule
bind antenna_driver_control antenna_chk #(.ACT_CYCLES(ACT_CYCLES), .INIT_CYCLES(INIT_CYCLES))
   u_chk (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_envelope(tx_envelope),
   .power_down(power_down), .driver_a_pin(driver_a_pin), .driver_b_pin(driver_b_pin),
   .force_full_ask(force_full_ask), .collision_avoid_enable(collision_avoid_enable),
   .wake_request(wake_request));

// ===== verif/antenna_driver_control_tb_top.sv
// Self-checking bench for the antenna driver control block
`timescale 1ns/1ps
module antenna_driver_control_tb_top;
   import antenna_pkg::*;
   localparam int ACT = 20; // Short activation delay
   localparam int INIT = 40; // Short initial delay
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [31:0] wb_adr_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic field_cmd = 1'b0; // Reader field wanted at far side
   logic tx_envelope = 1'b0;
   logic tx_last_bit = 1'b0;
   logic power_down = 1'b0;
   logic ext_field_in, rf_level_in, driver_a_pin, driver_b_pin, coil_on;
   logic force_full_ask, collision_avoid_enable, wake_request;
   logic [1:0] collision_slot;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   always #50 mclk = ~mclk;
   antenna_driver_control #(.ACT_CYCLES(ACT), .INIT_CYCLES(INIT)) DUT (
      .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_field_in(ext_field_in),
      .rf_level_in(rf_level_in), .tx_envelope(tx_envelope), .tx_last_bit(tx_last_bit),
      .power_down(power_down), .driver_a_pin(driver_a_pin), .driver_b_pin(driver_b_pin),
      .force_full_ask(force_full_ask), .collision_avoid_enable(collision_avoid_enable),
      .collision_slot(collision_slot), .wake_request(wake_request));
   field_partner #(.LAG(2)) u_far (.mclk(mclk), .field_cmd(field_cmd),
      .driver_a_pin(driver_a_pin), .driver_b_pin(driver_b_pin),
      .ext_field_in(ext_field_in), .rf_level_in(rf_level_in), .coil_on(coil_on));
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic pin_f(logic en, logic ion, logic ioff, logic env, logic cw);
      return (en & (cw | ~env)) ^ (en ? ion : ioff);
   endfunction
   // Classic cycle: hold until ack is seen high on a falling edge, release on the next rising edge
   task automatic wb_xfer(input logic [31:0] a, input logic w, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, d};
      @(negedge mclk);
      while (wb_ack_o !== 1'b1 && n < 20) begin
         n++;
         @(negedge mclk);
      end
      if (n == 20) begin
         mismatches++;
      end
      @(posedge mclk);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb_xfer(a, 1'b1, d, q);
   endtask
   task automatic rd_chk(input string what, input logic [31:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb_xfer(a, 1'b0, 8'h00, q);
      chk(what, {24'h0, e}, {24'h0, q});
   endtask
   // Count cycles until driver A gate comes up
   task automatic wait_pin_a(output int n);
      n = 0;
      while (driver_a_pin !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic t_regs();
      rd_chk("control reset", CONTROL_ADDR, 8'h80);
      rd_chk("auto reset", AUTO_ADDR, 8'h00);
      wr(32'h0001_0000, 8'hff);
      rd_chk("unmapped", 32'h0001_0000, 8'h00);
      wr(CONTROL_ADDR, 8'hfc);
      rd_chk("check bit write only", CONTROL_ADDR, 8'hf8);
      wr(AUTO_ADDR, 8'hfc);
      rd_chk("auto access", AUTO_ADDR, 8'he8);
      wr(AUTO_ADDR, 8'h00);
      $display("regs done");
   endtask
   task automatic t_pins();
      logic [7:0] tbl [0:9];
      tbl = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h80, 8'h01, 8'h02, 8'h41, 8'h82, 8'h0a};
      for (int i = 0; i < 10; i++) begin
         wr(CONTROL_ADDR, tbl[i]);
         for (int e = 0; e < 2; e++) begin
            @(posedge mclk);
            tx_envelope <= e[0];
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            chk("pin a", {31'h0, pin_f(tbl[i][0], tbl[i][6], tbl[i][4], e[0], 1'b0)},
               {31'h0, driver_a_pin});
            chk("pin b", {31'h0, pin_f(tbl[i][1], tbl[i][7], tbl[i][5], e[0], tbl[i][3])},
               {31'h0, driver_b_pin});
         end
      end
      $display("pins done");
   endtask
   task automatic t_ask_wake();
      wr(AUTO_ADDR, 8'h68);
      @(negedge mclk);
      chk("full ask", 32'h1, {31'h0, force_full_ask});
      chk("ca on", 32'h1, {31'h0, collision_avoid_enable});
      @(posedge mclk);
      power_down <= 1'b1;
      field_cmd <= 1'b1;
      repeat (10) @(posedge mclk);
      chk("wake", 32'h1, {31'h0, wake_request});
      wr(AUTO_ADDR, 8'h48);
      repeat (2) @(posedge mclk);
      chk("wake off", 32'h0, {31'h0, wake_request});
      power_down <= 1'b0;
      wr(AUTO_ADDR, 8'h00);
      @(negedge mclk);
      chk("ask off", 32'h0, {31'h0, force_full_ask});
      $display("ask wake done");
   endtask
   task automatic t_auto_on();
      int n;
      wr(CONTROL_ADDR, 8'h80);
      tx_envelope <= 1'b0;
      wr(AUTO_ADDR, 8'h03);
      repeat (30) @(posedge mclk);
      chk("held under field", 32'h0, {31'h0, driver_a_pin});
      field_cmd <= 1'b0;
      wait_pin_a(n);
      chk("activation delay", 32'h1, {31'h0, n >= ACT && n <= ACT + 15});
      chk("coil fed", 32'h1, {31'h0, coil_on});
      chk("slot idle", 32'h0, {30'h0, collision_slot});
      rd_chk("auto enables", CONTROL_ADDR, 8'h83);
      $display("auto on done");
   endtask
   task automatic t_initial();
      int n;
      wr(AUTO_ADDR, 8'h00);
      wr(CONTROL_ADDR, 8'h84);
      wr(AUTO_ADDR, 8'h07);
      repeat (10) @(posedge mclk);
      field_cmd <= 1'b1;
      repeat (INIT + 30) @(posedge mclk);
      chk("initial aborted", 32'h0, {31'h0, driver_a_pin});
      field_cmd <= 1'b0;
      wait_pin_a(n);
      chk("initial late on", 32'h1, {31'h0, n >= ACT && n < 300});
      rd_chk("initial enables", CONTROL_ADDR, 8'h83);
      $display("initial done");
   endtask
   task automatic t_auto_off();
      wr(AUTO_ADDR, 8'h80);
      wr(CONTROL_ADDR, 8'h83);
      tx_last_bit <= 1'b1;
      @(posedge mclk);
      tx_last_bit <= 1'b0;
      rd_chk("auto field off", CONTROL_ADDR, 8'h80);
      wr(AUTO_ADDR, 8'h00);
      $display("auto off done");
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_pins();
      t_ask_wake();
      t_auto_on();
      t_initial();
      t_auto_off();
      conclude();
   end
endmodule
